//--- common/glme_pkg.sv
// Package with register map, field positions and reset values for the logic-mode event block.
//
// Summary of operation
// - Delta AND mode when delta/value select is 0 and and/or select is 1.
// - Value AND mode when delta/value select and and/or select are both 1.
// - Delta AND: all high-masked rise flags and low-masked fall flags set.
// - Rise and fall flags are independent, each gated by its own mask.
// - A pin starting high needs low then high before its rise term holds.
// - With all mask bits clear, neither AND mode asserts the event while logic polarity is 0.
// - Value AND: high-masked pins read high and low-masked pins read low.
// - Value AND never asserts while logic polarity is 0 if any pin has both masks set.
// - Value AND asserts at once on entry if levels match, else on match.
// - Value AND needs all masked levels to hold at the same moment.
// - Pin 0 output drives its value bit or the logic event per source bit.
// - The pin 0 output-source bit is ignored while pin 0 is an input.
// - Event line 0 comes from pin 0 pass-through or the logic event.
// - Pin 0 as output keeps the logic event but kills its pass-through.
// - Event lines 1 to 15 come only from pass-through logic.
// - All event lines go to the transfer controller; 0 and 4-7 interrupt.
// - Pass-through lines follow their pin, true or inverted by polarity.
// - Logic output polarity 1 asserts the event when the logic is false, in the two AND modes only.
// - Event line 0 carries the logic event when its source select is 1.
// - Value mode gates pin level with high mask, inverted with low mask.
package glme_pkg;
    localparam int NPIN = 16;
    localparam logic [7:0] ADDR_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_DIR = 8'h04;
    localparam logic [7:0] ADDR_VALUE = 8'h08;
    localparam logic [7:0] ADDR_RISE = 8'h0C;
    localparam logic [7:0] ADDR_FALL = 8'h10;
    localparam logic [7:0] ADDR_HMASK = 8'h14;
    localparam logic [7:0] ADDR_LMASK = 8'h18;
    localparam logic [7:0] ADDR_GCTRL = 8'h1C;
    localparam logic [7:0] ADDR_POL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam int GC_P0SRC = 0;
    localparam int GC_EV0SEL = 1;
    localparam int GC_LOGIC = 2;
    localparam int GC_DV = 3;
    localparam int GC_LPOL = 4;
    localparam int GC_W = 5;
    localparam logic [15:0] RST_PINS = 16'h0000;
    localparam logic [4:0] RST_GCTRL = 5'h00;
    localparam logic [15:0] CPU_INT_MASK = 16'h00F1;
endpackage : glme_pkg

//--- logic/glme_event_gen.sv
// Logic-mode event generator with pass-through event lines and APB registers.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module glme_event_gen (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [15:0] pin_in,
    output logic pin0_out,
    output logic pin0_oe_out,
    output logic logic_event_out,
    output logic [15:0] edma_event_out,
    output logic [15:0] cpu_int_out
);
    localparam int N = glme_pkg::NPIN;

    // ********************************************************
    // Pin synchronisers and edge detection
    // ********************************************************
    logic [N-1:0] sync1_q, sync2_q, prev_q;
    logic [N-1:0] enable_q, dir_q, value_q, rise_q, fall_q;
    logic [N-1:0] hmask_q, lmask_q, pol_q;
    logic [glme_pkg::GC_W-1:0] gctrl_q;
    logic [31:0] prdata_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q <= glme_pkg::RST_PINS;
            sync2_q <= glme_pkg::RST_PINS;
            prev_q <= glme_pkg::RST_PINS;
        end else if (ce_in) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    wire [N-1:0] in_use = enable_q & ~dir_q;
    // An edge is seen only by an enabled input; prev_q starts from the
    // synchronised level so a pin already high gives no rise.
    wire [N-1:0] rise_ev = in_use & sync2_q & ~prev_q;
    wire [N-1:0] fall_ev = in_use & ~sync2_q & prev_q;

    // ********************************************************
    // APB slave
    // ********************************************************
    wire wr_acc = psel_in & penable_in & pwrite_in & ce_in;
    wire rd_acc = psel_in & penable_in & ~pwrite_in & ce_in;
    wire hit_en = paddr_in == glme_pkg::ADDR_ENABLE;
    wire hit_dir = paddr_in == glme_pkg::ADDR_DIR;
    wire hit_val = paddr_in == glme_pkg::ADDR_VALUE;
    wire hit_rise = paddr_in == glme_pkg::ADDR_RISE;
    wire hit_fall = paddr_in == glme_pkg::ADDR_FALL;
    wire hit_hm = paddr_in == glme_pkg::ADDR_HMASK;
    wire hit_lm = paddr_in == glme_pkg::ADDR_LMASK;
    wire hit_gc = paddr_in == glme_pkg::ADDR_GCTRL;
    wire hit_pol = paddr_in == glme_pkg::ADDR_POL;
    wire hit_st = paddr_in == glme_pkg::ADDR_STATUS;
    wire mapped = hit_en | hit_dir | hit_val | hit_rise | hit_fall | hit_hm
                | hit_lm | hit_gc | hit_pol | hit_st;
    wire [15:0] wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    wire [15:0] wdat = pwdata_in[15:0];

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nv,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction : merge

    // Writing a one clears a detect flag; a new edge in the same cycle wins.
    wire [N-1:0] rise_clr = (wr_acc & hit_rise) ? (wdat & wmask) : '0;
    wire [N-1:0] fall_clr = (wr_acc & hit_fall) ? (wdat & wmask) : '0;
    wire [N-1:0] rise_d = (rise_q & ~rise_clr) | rise_ev;
    wire [N-1:0] fall_d = (fall_q & ~fall_clr) | fall_ev;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            enable_q <= glme_pkg::RST_PINS;
            dir_q <= glme_pkg::RST_PINS;
            value_q <= glme_pkg::RST_PINS;
            hmask_q <= glme_pkg::RST_PINS;
            lmask_q <= glme_pkg::RST_PINS;
            pol_q <= glme_pkg::RST_PINS;
            rise_q <= glme_pkg::RST_PINS;
            fall_q <= glme_pkg::RST_PINS;
            gctrl_q <= glme_pkg::RST_GCTRL;
        end else if (ce_in) begin
            rise_q <= rise_d;
            fall_q <= fall_d;
            if (wr_acc && hit_en) enable_q <= merge(enable_q, wdat, wmask);
            if (wr_acc && hit_dir) dir_q <= merge(dir_q, wdat, wmask);
            if (wr_acc && hit_val) value_q <= merge(value_q, wdat, wmask);
            if (wr_acc && hit_hm) hmask_q <= merge(hmask_q, wdat, wmask);
            if (wr_acc && hit_lm) lmask_q <= merge(lmask_q, wdat, wmask);
            if (wr_acc && hit_pol) pol_q <= merge(pol_q, wdat, wmask);
            if (wr_acc && hit_gc && pstrb_in[0]) begin
                gctrl_q <= pwdata_in[glme_pkg::GC_W-1:0];
            end
        end
    end

    // ********************************************************
    // Logic-mode evaluation
    // ********************************************************
    wire dv_sel = gctrl_q[glme_pkg::GC_DV];
    wire and_sel = gctrl_q[glme_pkg::GC_LOGIC];
    wire delta_and = !dv_sel && and_sel;
    wire value_and = dv_sel && and_sel;
    wire any_mask = |(hmask_q | lmask_q);
    wire [N-1:0] lvl = sync2_q & in_use;
    // Unused pins read low to the value path, as disabled pins must not count.
    wire delta_ok = &((rise_q | ~hmask_q) & (fall_q | ~lmask_q));
    wire value_ok = &((lvl | ~hmask_q) & (~lvl | ~lmask_q));
    wire both_mask = |(hmask_q & lmask_q);
    wire comb_true = any_mask &&
        ((delta_and && delta_ok) ||
         (value_and && value_ok && !both_mask));
    wire active_mode = delta_and || value_and;
    // Polarity inverts only inside a supported mode so a reserved setting
    // stays quiet.
    wire lev = active_mode &&
        (gctrl_q[glme_pkg::GC_LPOL] ? !comb_true : comb_true);

    // ********************************************************
    // Event lines and pin 0 output
    // ********************************************************
    wire [N-1:0] pass = (sync2_q ^ pol_q) & in_use;
    wire ev0 = gctrl_q[glme_pkg::GC_EV0SEL] ? lev : pass[0];
    wire [N-1:0] events = {pass[N-1:1], ev0};
    wire p0_drv = enable_q[0] && dir_q[0];
    // Output source only matters while pin 0 is an enabled output.
    wire p0_val = gctrl_q[glme_pkg::GC_P0SRC] ? lev : value_q[0];

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            logic_event_out <= 1'b0;
            edma_event_out <= 16'h0000;
            cpu_int_out <= 16'h0000;
            pin0_out <= 1'b0;
            pin0_oe_out <= 1'b0;
        end else if (ce_in) begin
            logic_event_out <= lev;
            edma_event_out <= events;
            cpu_int_out <= events & glme_pkg::CPU_INT_MASK;
            pin0_out <= p0_drv ? p0_val : 1'b0;
            pin0_oe_out <= p0_drv;
        end
    end

    wire [31:0] rd_mux =
        hit_en ? {16'h0000, enable_q} :
        hit_dir ? {16'h0000, dir_q} :
        hit_val ? {16'h0000, value_q} :
        hit_rise ? {16'h0000, rise_q} :
        hit_fall ? {16'h0000, fall_q} :
        hit_hm ? {16'h0000, hmask_q} :
        hit_lm ? {16'h0000, lmask_q} :
        hit_gc ? {27'h0000000, gctrl_q} :
        hit_pol ? {16'h0000, pol_q} :
        hit_st ? {16'h0000, sync2_q} : 32'h00000000;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prdata_q <= 32'h00000000;
        end else if (ce_in && psel_in && !penable_in && !pwrite_in) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = 1'b1;
    assign pslverr_out = (rd_acc | wr_acc) & ~mapped;

    // ********************************************************
    // Checks
    // ********************************************************
    a_empty_mask_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && !any_mask && !gctrl_q[glme_pkg::GC_LPOL])
        |=> !logic_event_out)
        else $error("logic event with no mask bits");
    a_both_mask_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && value_and && both_mask && !gctrl_q[glme_pkg::GC_LPOL])
        |=> !logic_event_out)
        else $error("value AND fired with both masks on a pin");
    a_delta_fires: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && delta_and && any_mask && delta_ok
         && !gctrl_q[glme_pkg::GC_LPOL]) |=> logic_event_out)
        else $error("delta AND missed");
    a_value_fires: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && value_and && any_mask && !both_mask && value_ok
         && !gctrl_q[glme_pkg::GC_LPOL]) |=> logic_event_out)
        else $error("value AND missed");
    a_flag_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && rise_q[1] && !(wr_acc && hit_rise)) |=> rise_q[1])
        else $error("rise flag dropped without clear");
    a_ev0_logic: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && gctrl_q[glme_pkg::GC_EV0SEL])
        |=> edma_event_out[0] == $past(lev))
        else $error("event line 0 not carrying logic event");
    a_pass_output: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && dir_q[2]) |=> !edma_event_out[2])
        else $error("pass-through on output pin");
    a_cpu_lines: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ce_in |=> cpu_int_out[3:1] == 3'h0 && cpu_int_out[15:8] == 8'h00)
        else $error("cpu interrupt on a line not routed");
    a_pin0_source: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && p0_drv && !gctrl_q[glme_pkg::GC_P0SRC])
        |=> pin0_out == $past(value_q[0]))
        else $error("pin 0 not driving value bit");

    // ********************************************************
    // Mode, flag and routing checks
    // ********************************************************
    // The reserved code and delta OR are left out of this block, so both
    // must keep the logic event low whatever the polarity bit says.
    a_reserved_quiet: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && !active_mode)
        |=> !logic_event_out)
        else $error("logic event outside the AND modes");
    // Polarity flips the registered event one cycle after the combination.
    a_pol_invert: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && active_mode && gctrl_q[glme_pkg::GC_LPOL])
        |=> logic_event_out == !$past(comb_true))
        else $error("inverted logic event wrong");
    a_value_level: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && value_and && !value_ok)
        |=> logic_event_out == $past(gctrl_q[glme_pkg::GC_LPOL]))
        else $error("value AND fired without a full match");
    a_delta_wait: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && delta_and && !delta_ok)
        |=> logic_event_out == $past(gctrl_q[glme_pkg::GC_LPOL]))
        else $error("delta AND fired before all flags");
    // A flag can only rise through a detected edge, so a pin that starts
    // high cannot satisfy its rise term before it has been low.
    a_rise_needs_edge: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && !rise_q[1] && !rise_ev[1])
        |=> !rise_q[1])
        else $error("rise flag set without an edge");
    a_clear_set_wins: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && rise_ev[1])
        |=> rise_q[1])
        else $error("rise edge lost");
    a_fall_sticky: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && fall_q[2] && !(wr_acc && hit_fall))
        |=> fall_q[2])
        else $error("fall flag dropped without clear");
    a_flag_no_output: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && !in_use[3] && !fall_q[3])
        |=> !fall_q[3])
        else $error("flag set on a pin that is not an input");
    // Lines 1 to 15 never see the logic event; line 0 follows its select.
    a_pass_lines: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ce_in
        |=> edma_event_out[15:1] == $past(pass[15:1]))
        else $error("pass-through line wrong");
    a_ev0_pass: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && !gctrl_q[glme_pkg::GC_EV0SEL])
        |=> edma_event_out[0] == $past(pass[0]))
        else $error("event line 0 not carrying pass-through");
    a_cpu_match: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ce_in |=> cpu_int_out[0] == edma_event_out[0]
            && cpu_int_out[7:4] == edma_event_out[7:4])
        else $error("interrupt line differs from its event");
    // The pin drive is registered, so it lags the source by one cycle.
    a_pin0_logic: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && p0_drv && gctrl_q[glme_pkg::GC_P0SRC])
        |=> pin0_out == $past(lev))
        else $error("pin 0 not driving logic event");
    a_pin0_oe_tracks: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ce_in
        |=> pin0_oe_out == $past(p0_drv))
        else $error("pin 0 enable wrong");
    a_pin0_input: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        (ce_in && !dir_q[0])
        |=> !pin0_oe_out && !pin0_out)
        else $error("pin 0 driven while an input");
endmodule : glme_event_gen

`default_nettype wire

//--- sim/glme_event_gen_tb_top.sv
// Self-checking testbench for the logic-mode event generator.
`timescale 1ns/10ps
`default_nettype none
`define CMP(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module glme_event_gen_tb_top;
    typedef struct {int sel; logic [31:0] e;} glme_note_t;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic smp = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] pins = 16'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic perr = 1'b0;
    logic p0;
    logic p0oe;
    logic lev;
    logic [15:0] edma;
    logic [15:0] cpu;
    glme_note_t notes[$];
    glme_note_t nt;
    string nm[6] = '{"prdata", "event", "edma", "cpu", "pin0", "pslverr"};
    int miscompares = 0;
    int num_checks = 0;
    logic [15:0] rp;
    logic [15:0] rq;
    always #10 clk_in = ~clk_in;
    glme_event_gen glme_event_gen_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .ce_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_in(pins), .pin0_out(p0), .pin0_oe_out(p0oe),
        .logic_event_out(lev), .edma_event_out(edma), .cpu_int_out(cpu));
    // ****************************************
    // Bus tasks and the result watcher
    // ****************************************
    function automatic logic [31:0] obs(input int s);
        case (s)
            0: return prdata;
            1: return {31'h0, lev};
            2: return {16'h0, edma};
            3: return {16'h0, cpu};
            4: return {30'h0, p0oe, p0};
            default: return {31'h0, perr};
        endcase
    endfunction : obs
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) @(posedge clk_in);
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clk_in);
    endtask : wr
    // The note is queued before the strobe so the watcher always finds it.
    task automatic chk(input int s, input logic [31:0] e);
        notes.push_back('{s, e});
        smp <= 1'b1;
        @(posedge clk_in);
        smp <= 1'b0;
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(0, e);
    endtask : rd
    task automatic pin(input logic [15:0] v);
        pins <= v;
        repeat (6) @(posedge clk_in);
    endtask : pin
    always @(posedge clk_in) begin
        if (smp) begin
            nt = notes.pop_front();
            `CMP(nm[nt.sel], nt.e, obs(nt.sel))
        end
    end
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(99));
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        rd(glme_pkg::ADDR_GCTRL, 32'h0);
        chk(5, 32'h0);
        rd(8'h3C, 32'h0);
        chk(5, 32'h1);
        pins <= 16'h0006;
        wr(glme_pkg::ADDR_ENABLE, 32'h0006);
        wr(glme_pkg::ADDR_HMASK, 32'h0002);
        wr(glme_pkg::ADDR_LMASK, 32'h0004);
        wr(glme_pkg::ADDR_RISE, 32'hFFFF);
        wr(glme_pkg::ADDR_FALL, 32'hFFFF);
        rd(glme_pkg::ADDR_RISE, 32'h0);
        wr(glme_pkg::ADDR_GCTRL, 32'h04);
        chk(1, 32'h0);
        pin(16'h0002);
        chk(1, 32'h0);
        pin(16'h0000);
        chk(1, 32'h0);
        pin(16'h0002);
        chk(1, 32'h1);
        rd(glme_pkg::ADDR_RISE, 32'h0002);
        rd(glme_pkg::ADDR_FALL, 32'h0006);
        wr(glme_pkg::ADDR_GCTRL, 32'h14);
        chk(1, 32'h0);
        wr(glme_pkg::ADDR_HMASK, 32'h0);
        wr(glme_pkg::ADDR_LMASK, 32'h0);
        wr(glme_pkg::ADDR_GCTRL, 32'h04);
        chk(1, 32'h0);
        $display("Test delta done");
        wr(glme_pkg::ADDR_HMASK, 32'h0002);
        wr(glme_pkg::ADDR_LMASK, 32'h0004);
        wr(glme_pkg::ADDR_GCTRL, 32'h0C);
        chk(1, 32'h1);
        pin(16'h0006);
        chk(1, 32'h0);
        pin(16'h0000);
        pin(16'h0006);
        chk(1, 32'h0);
        pin(16'h0002);
        chk(1, 32'h1);
        wr(glme_pkg::ADDR_LMASK, 32'h0006);
        chk(1, 32'h0);
        wr(glme_pkg::ADDR_LMASK, 32'h0004);
        $display("Test value done");
        pin(16'h0003);
        wr(glme_pkg::ADDR_ENABLE, 32'h0007);
        wr(glme_pkg::ADDR_DIR, 32'h0005);
        wr(glme_pkg::ADDR_VALUE, 32'h0001);
        chk(4, 32'h3);
        chk(2, 32'h2);
        wr(glme_pkg::ADDR_VALUE, 32'h0);
        wr(glme_pkg::ADDR_GCTRL, 32'h0D);
        chk(4, 32'h3);
        wr(glme_pkg::ADDR_GCTRL, 32'h0F);
        chk(2, 32'h3);
        chk(3, 32'h1);
        wr(glme_pkg::ADDR_DIR, 32'h0);
        chk(4, 32'h0);
        $display("Test pin zero done");
        wr(glme_pkg::ADDR_ENABLE, 32'hFFFF);
        wr(glme_pkg::ADDR_GCTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rp = 16'($urandom());
            rq = 16'($urandom());
            wr(glme_pkg::ADDR_POL, {16'h0, rq});
            pin(rp);
            chk(2, {16'h0, rp ^ rq});
            chk(3, {16'h0, (rp ^ rq) & glme_pkg::CPU_INT_MASK});
        end
        $display("Test pass-through done");
        conclude();
    end
endmodule : glme_event_gen_tb_top
`default_nettype wire
